/* logic/lpt_cfg.svh */
// constants for the light/proximity threshold interrupt block
`ifndef LPT_CFG_SVH
`define LPT_CFG_SVH
// ====================================================
// register byte offsets
`define LPT_OFF_CTRL      12'h000
`define LPT_OFF_PS_THR    12'h004
`define LPT_OFF_AL_THR    12'h008
`define LPT_OFF_STAT      12'h00C
`define LPT_OFF_MASK      12'h010
`define LPT_OFF_CMD       12'h014
`define LPT_OFF_INTREG    12'h018
`define LPT_OFF_PS_CNT    12'h01C
`define LPT_OFF_AL_CNT    12'h020
// ====================================================
// control fields
`define LPT_CTRL_PS_EN    0
`define LPT_CTRL_AL_EN    1
`define LPT_CTRL_LATCH    2
`define LPT_CTRL_MODE_LO  4
`define LPT_CTRL_MODE_HI  5
// command bits
`define LPT_CMD_INT_RST   0
`define LPT_CMD_SW_RST    1
`define LPT_CMD_PWR_DN    2
// status / mask bits
`define LPT_ST_PS         0
`define LPT_ST_AL         1
// ====================================================
// reset values
`define LPT_RST_CTRL      32'h0000_0023
`define LPT_RST_THR       32'h0000_FFFF
`define LPT_RST_MASK      2'h0
`endif

/* logic/lpt_pkg.sv */
// types for the light/proximity threshold interrupt block
package lpt_pkg;
   // proximity comparison modes
   typedef enum logic [1:0]
   {
      LPT_PS_HIGH = 2'h0,
      LPT_PS_HYST = 2'h1,
      LPT_PS_OUT  = 2'h2,
      LPT_PS_RSV  = 2'h3
   } lpt_ps_mode_e;
   // a pair of window thresholds
   typedef struct packed
   {
      logic [15:0] high;
      logic [15:0] low;
   } lpt_thr_s;
   // one measurement result
   typedef struct packed
   {
      logic        valid;
      logic [15:0] count;
   } lpt_meas_s;
endpackage : lpt_pkg

/* logic/lpt_cmp.sv */
// window comparator for one channel
`timescale 1ns/1ps
module lpt_cmp
(
   // mode and thresholds
   input  wire logic                 hyst_i,
   input  wire logic                 outside_i,
   input  wire lpt_pkg::lpt_thr_s    thr_i,
   // count and present state
   input  wire logic [15:0]          count_i,
   input  wire logic                 cur_i,
   // decision
   output logic                      act_o
);
   // next activity of the channel for a new count
   always_comb
   begin
      if (outside_i)
         act_o = (count_i > thr_i.high) || (count_i < thr_i.low);
      else if (hyst_i)
         act_o = (count_i > thr_i.high) ? 1'b1 : ((count_i < thr_i.low) ? 1'b0 : cur_i);
      else
         act_o = (count_i > thr_i.high);
   end
endmodule : lpt_cmp

/* logic/lpt_irq.sv */
// light/proximity threshold interrupt decision with ahb-lite registers
`timescale 1ns/1ps
`include "lpt_cfg.svh"
// How it works
// RULE_01: in outside-window mode and unlatched output the alert releases while the proximity count is in the window.
// RULE_02: in outside-window mode the alert asserts whenever the proximity count leaves the low..high window.
// RULE_03: the visible light count against its window asserts outside and releases inside when unlatched.
// RULE_04: when latched, an asserted alert holds until an interrupt reset command or an interrupt register read.
// RULE_05: mode zero compares against high only, mode one uses high to set and low to clear.
// RULE_06: the alert pin only pulls low, holds over power down, and floats after int reset, int read or soft reset; in power down only soft reset does.
// RULE_07: comparisons are made only when a new proximity or ambient result arrives.
module lpt_irq
(
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              resetn_i,
   // ahb-lite slave
   input  wire logic              hsel_i,
   input  wire logic [11:0]       haddr_i,
   input  wire logic [1:0]        htrans_i,
   input  wire logic              hwrite_i,
   input  wire logic [2:0]        hsize_i,
   input  wire logic [31:0]       hwdata_i,
   input  wire logic              hready_i,
   output logic      [31:0]       hrdata_o,
   output logic                   hreadyout_o,
   output logic                   hresp_o,
   // measurement results
   input  wire lpt_pkg::lpt_meas_s ps_meas_i,
   input  wire lpt_pkg::lpt_meas_s al_meas_i,
   // open-drain alert pin and interrupt
   output logic                   alert_n_out_o,
   output logic                   alert_n_oe_o,
   output logic                   irq_o
);
   // ====================================================
   // registers
   logic [31:0]       ctrl_q;
   lpt_pkg::lpt_thr_s ps_thr_q;
   lpt_pkg::lpt_thr_s al_thr_q;
   logic [1:0]        stat_q;
   logic [1:0]        mask_q;
   logic [15:0]       ps_cnt_q;
   logic [15:0]       al_cnt_q;
   logic              ps_act_q;
   logic              al_act_q;
   logic              alert_q;
   logic              pwr_dn_q;
   logic              wr_pend_q;
   logic              rd_pend_q;
   logic [11:0]       addr_q;
   logic              ps_act_d;
   logic              al_act_d;
   logic              int_rst;
   logic              sw_rst;
   logic              intreg_rd;
   logic              ps_new;
   logic              al_new;
   logic              latch;
   lpt_pkg::lpt_ps_mode_e ps_mode;

   // word address match
   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a[11:2] == off[11:2]);
   endfunction : hit

   // ====================================================
   // bus address phase capture
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q    <= 12'h000;
      end
      else if (hready_i)
      begin
         wr_pend_q <= hsel_i && htrans_i[1] && hwrite_i;
         rd_pend_q <= hsel_i && htrans_i[1] && !hwrite_i;
         addr_q    <= haddr_i;
      end
   end

   // zero wait state, always okay
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         hreadyout_o <= 1'b0;
         hresp_o     <= 1'b0;
      end
      else
      begin
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end
   end

   // command strobes
   assign int_rst   = wr_pend_q && hit(addr_q, `LPT_OFF_CMD) && hwdata_i[`LPT_CMD_INT_RST];
   assign sw_rst    = wr_pend_q && hit(addr_q, `LPT_OFF_CMD) && hwdata_i[`LPT_CMD_SW_RST];
   assign intreg_rd = rd_pend_q && hit(addr_q, `LPT_OFF_INTREG);
   assign ps_new    = ps_meas_i.valid && ctrl_q[`LPT_CTRL_PS_EN];
   assign al_new    = al_meas_i.valid && ctrl_q[`LPT_CTRL_AL_EN];
   assign latch     = ctrl_q[`LPT_CTRL_LATCH];
   assign ps_mode   = lpt_pkg::lpt_ps_mode_e'(ctrl_q[`LPT_CTRL_MODE_HI:`LPT_CTRL_MODE_LO]);

   // ====================================================
   // configuration registers, soft reset restores them
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ctrl_q   <= `LPT_RST_CTRL;
         ps_thr_q <= `LPT_RST_THR;
         al_thr_q <= `LPT_RST_THR;
         mask_q   <= `LPT_RST_MASK;
      end
      else if (sw_rst)
      begin
         ctrl_q   <= `LPT_RST_CTRL;
         ps_thr_q <= `LPT_RST_THR;
         al_thr_q <= `LPT_RST_THR;
         mask_q   <= `LPT_RST_MASK;
      end
      else if (wr_pend_q)
      begin
         if (hit(addr_q, `LPT_OFF_CTRL))
            ctrl_q <= {26'h0, hwdata_i[5:4], 1'b0, hwdata_i[2:0]};
         if (hit(addr_q, `LPT_OFF_PS_THR))
            ps_thr_q <= hwdata_i;
         if (hit(addr_q, `LPT_OFF_AL_THR))
            al_thr_q <= hwdata_i;
         if (hit(addr_q, `LPT_OFF_MASK))
            mask_q <= hwdata_i[1:0];
      end
   end

   // power down flag, alert keeps its state meanwhile
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         pwr_dn_q <= 1'b0;
      else if (sw_rst)
         pwr_dn_q <= 1'b0;
      else if (wr_pend_q && hit(addr_q, `LPT_OFF_CMD))
         pwr_dn_q <= hwdata_i[`LPT_CMD_PWR_DN]; // RULE_06
   end

   // ====================================================
   // comparators
   lpt_cmp u_ps_cmp
   (
      .hyst_i    (ps_mode == lpt_pkg::LPT_PS_HYST), // RULE_05
      .outside_i (ps_mode == lpt_pkg::LPT_PS_OUT),  // RULE_02
      .thr_i     (ps_thr_q),
      .count_i   (ps_meas_i.count),
      .cur_i     (ps_act_q),
      .act_o     (ps_act_d)
   );

   lpt_cmp u_al_cmp
   (
      .hyst_i    (1'b0),
      .outside_i (1'b1), // RULE_03
      .thr_i     (al_thr_q),
      .count_i   (al_meas_i.count),
      .cur_i     (al_act_q),
      .act_o     (al_act_d)
   );

   // channel activity, updated only on new results
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ps_act_q <= 1'b0;
         al_act_q <= 1'b0;
         ps_cnt_q <= 16'h0000;
         al_cnt_q <= 16'h0000;
      end
      else if (sw_rst)
      begin
         ps_act_q <= 1'b0;
         al_act_q <= 1'b0;
      end
      else if (!pwr_dn_q)
      begin
         if (ps_new) // RULE_07
         begin
            ps_act_q <= ps_act_d; // RULE_01
            ps_cnt_q <= ps_meas_i.count;
         end
         if (al_new) // RULE_07
         begin
            al_act_q <= al_act_d; // RULE_03
            al_cnt_q <= al_meas_i.count;
         end
      end
   end

   // ====================================================
   // alert state: follows activity or latches until cleared
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         alert_q <= 1'b0;
      else if (sw_rst)
         alert_q <= 1'b0; // RULE_06 soft reset floats the pin even in power down
      else if (pwr_dn_q)
         alert_q <= alert_q; // RULE_06
      else if ((ps_new && ps_act_d) || (al_new && al_act_d))
         alert_q <= 1'b1; // RULE_02
      else if (int_rst || intreg_rd)
         alert_q <= 1'b0; // RULE_04
      else if (!latch && (ps_new || al_new))
         alert_q <= (ps_new ? ps_act_d : ps_act_q) || (al_new ? al_act_d : al_act_q); // RULE_01
   end

   // open-drain alert pin, only ever pulls low
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         alert_n_out_o <= 1'b0;
         alert_n_oe_o  <= 1'b0;
      end
      else
      begin
         alert_n_out_o <= 1'b0;
         alert_n_oe_o  <= alert_q; // RULE_06
      end
   end

   // ====================================================
   // sticky status, set wins over write-one-to-clear
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         stat_q <= 2'h0;
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if ((i == 0) ? (ps_new && ps_act_d && !pwr_dn_q) : (al_new && al_act_d && !pwr_dn_q))
               stat_q[i] <= 1'b1;
            else if (wr_pend_q && hit(addr_q, `LPT_OFF_STAT) && hwdata_i[i])
               stat_q[i] <= 1'b0;
         end
      end
   end

   // level interrupt from masked status
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         irq_o <= 1'b0;
      else
         irq_o <= |(stat_q & mask_q);
   end

   // ====================================================
   // read data, registered in the address phase
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         hrdata_o <= 32'h0000_0000;
      else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i)
      begin
         if (hit(haddr_i, `LPT_OFF_CTRL))
            hrdata_o <= ctrl_q;
         else if (hit(haddr_i, `LPT_OFF_PS_THR))
            hrdata_o <= ps_thr_q;
         else if (hit(haddr_i, `LPT_OFF_AL_THR))
            hrdata_o <= al_thr_q;
         else if (hit(haddr_i, `LPT_OFF_STAT))
            hrdata_o <= {30'h0, stat_q};
         else if (hit(haddr_i, `LPT_OFF_MASK))
            hrdata_o <= {30'h0, mask_q};
         else if (hit(haddr_i, `LPT_OFF_INTREG))
            hrdata_o <= {28'h0, pwr_dn_q, alert_q, al_act_q, ps_act_q};
         else if (hit(haddr_i, `LPT_OFF_PS_CNT))
            hrdata_o <= {16'h0, ps_cnt_q};
         else if (hit(haddr_i, `LPT_OFF_AL_CNT))
            hrdata_o <= {16'h0, al_cnt_q};
         else
            hrdata_o <= 32'h0000_0000;
      end
   end
endmodule : lpt_irq

/* sim/lpt_host_pin.sv */
// host side of the open-drain alert line with its pull-up
`timescale 1ns/1ps
module lpt_host_pin
(
   // pin drive from the block
   input  wire logic alert_n_out_i,
   input  wire logic alert_n_oe_i,
   // level the host sees
   output logic      alert_n_o
);
   // ==========
   // pull-up wins while the block leaves the line floating
   assign alert_n_o = alert_n_oe_i ? alert_n_out_i : 1'b1;
endmodule : lpt_host_pin

/* sim/lpt_irq_assertions.sv */
// assertion checker for the threshold interrupt block
`timescale 1ns/1ps
`include "lpt_cfg.svh"
module lpt_chk
(
   // clock, reset and bus
   input wire logic               clk_i,
   input wire logic               resetn_i,
   input wire logic               hsel_i,
   input wire logic [11:0]        haddr_i,
   input wire logic [1:0]         htrans_i,
   input wire logic               hwrite_i,
   input wire logic [31:0]        hwdata_i,
   input wire logic               hready_i,
   // results and pin
   input wire lpt_pkg::lpt_meas_s ps_meas_i,
   input wire lpt_pkg::lpt_meas_s al_meas_i,
   input wire logic               alert_n_out_o,
   input wire logic               alert_n_oe_o
);
   logic [11:0] a_q;
   logic        w_q;
   logic [7:0]  ctl_q;
   logic [31:0] pt_q;
   logic [31:0] at_q;
   logic        pd_q;
   logic [2:0]  xc_q;
   logic [2:0]  qc_q;
   wire         adr = hsel_i && htrans_i[1] && hready_i;
   wire         vld = ps_meas_i.valid || al_meas_i.valid;
   wire         pok = ps_meas_i.valid && !pd_q;
   wire  [15:0] pc = ps_meas_i.count;
   wire  [15:0] ac = al_meas_i.count;
   wire         pout = pc > pt_q[31:16] || pc < pt_q[15:0];
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // ==========
   // shadow of control, thresholds and power down
   always_ff @(posedge clk_i or negedge resetn_i)
      if (!resetn_i)
      begin
         w_q <= 1'b0;
         a_q <= 12'h000;
         ctl_q <= 8'h23;
         pt_q <= 32'h0000_FFFF;
         at_q <= 32'h0000_FFFF;
         pd_q <= 1'b0;
      end
      else
      begin
         w_q <= adr && hwrite_i;
         a_q <= haddr_i;
         if (w_q && a_q == `LPT_OFF_CTRL) ctl_q <= hwdata_i[7:0];
         if (w_q && a_q == `LPT_OFF_PS_THR) pt_q <= hwdata_i;
         if (w_q && a_q == `LPT_OFF_AL_THR) at_q <= hwdata_i;
         if (w_q && a_q == `LPT_OFF_CMD) pd_q <= hwdata_i[2] && !hwdata_i[1];
         if (w_q && a_q == `LPT_OFF_CMD && hwdata_i[1])
         begin
            ctl_q <= 8'h23;
            pt_q <= 32'h0000_FFFF;
            at_q <= 32'h0000_FFFF;
         end
      end
   // cycles since the last bus transfer, and since any stimulus
   always_ff @(posedge clk_i or negedge resetn_i)
      if (!resetn_i)
      begin
         xc_q <= 3'h0;
         qc_q <= 3'h0;
      end
      else
      begin
         xc_q <= adr ? 3'h0 : xc_q + {2'h0, xc_q != 3'h7};
         qc_q <= (adr || vld) ? 3'h0 : qc_q + {2'h0, qc_q != 3'h7};
      end
   pin_drive_a: assert property (alert_n_oe_o |-> !alert_n_out_o)
      else $error("alert pin driven high");
   oe_cause_a: assert property ($rose(alert_n_oe_o) |-> $past(vld, 2))
      else $error("alert rose without a result");
   oe_quiet_a: assert property (qc_q > 3'h3 |-> $stable(alert_n_oe_o))
      else $error("alert moved while idle");
   latch_hold_a: assert property (ctl_q[2] && alert_n_oe_o && xc_q > 3'h3 |=> alert_n_oe_o)
      else $error("latched alert dropped");
   ps_out_a: assert property (ctl_q == 8'h21 && pok && pout |-> ##2 alert_n_oe_o)
      else $error("outside count gave no alert");
   ps_in_a: assert property (ctl_q == 8'h21 && pok && !pout |-> ##2 !alert_n_oe_o)
      else $error("inside count kept alert");
   hi_only_a: assert property (ctl_q == 8'h01 && pok |-> ##2 alert_n_oe_o == $past(pc > pt_q[31:16], 2))
      else $error("high only compare wrong");
   hyst_off_a: assert property (ctl_q == 8'h11 && pok && pc < pt_q[15:0] |-> ##2 !alert_n_oe_o)
      else $error("hysteresis release wrong");
   al_win_a: assert property (ctl_q == 8'h22 && al_meas_i.valid && !pd_q |-> ##2
      alert_n_oe_o == $past(ac > at_q[31:16] || ac < at_q[15:0], 2))
      else $error("ambient window compare wrong");
   cover property ($rose(alert_n_oe_o));
   cover property (ctl_q[2] && $fell(alert_n_oe_o));
   cover property (pd_q && alert_n_oe_o);
endmodule : lpt_chk
bind lpt_irq lpt_chk u_chk
(
   .clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
   .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i), .ps_meas_i(ps_meas_i),
   .al_meas_i(al_meas_i), .alert_n_out_o(alert_n_out_o), .alert_n_oe_o(alert_n_oe_o)
);

/* sim/lpt_irq_test.sv */
// self-checking bench for the threshold interrupt block
`timescale 1ns/1ps
`include "lpt_cfg.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module lpt_irq_test;
   logic clk_i, resetn_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, alert_n_out_o, alert_n_oe_o, irq_o, pin;
   logic [11:0] haddr_i;
   logic [1:0]  htrans_i;
   logic [2:0]  hsize_i;
   logic [31:0] hwdata_i, hrdata_o, e, q[$];
   logic [15:0] c;
   logic [7:0]  lc;
   logic        pv;
   logic        rdp = 1'b0;
   logic        pchk = 1'b0;
   lpt_pkg::lpt_meas_s ps_meas_i, al_meas_i;
   int          mismatches = 0;
   int          n_compared = 0;
   int          seed = 93325;
   int          i;
   logic [31:0] tbl [17] = '{32'h2201_0032, 32'h2200_0064, 32'h2201_012D, 32'h2200_012C, 32'h2210_0032,
      32'h2111_0063, 32'h2110_0064, 32'h2110_00C8, 32'h2111_00C9, 32'h2110_0096, 32'h0111_00C9,
      32'h0110_0032, 32'h0110_00C8, 32'h1111_00FA, 32'h1111_0096, 32'h1110_0063, 32'h1110_0096};
   lpt_irq uut
   (
      .clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
      .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
      .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .ps_meas_i(ps_meas_i),
      .al_meas_i(al_meas_i), .alert_n_out_o(alert_n_out_o), .alert_n_oe_o(alert_n_oe_o), .irq_o(irq_o)
   );
   lpt_host_pin u_host (.alert_n_out_i(alert_n_out_o), .alert_n_oe_i(alert_n_oe_o), .alert_n_o(pin));
   // ==========
   // clock
   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   // result watcher: oldest note against each read or pin sample
   always @(posedge clk_i)
   begin
      if (rdp && hreadyout_o)
      begin
         e = q.pop_front();
         `CHK(hrdata_o, e)
         `CHK(hresp_o, 1'b0)
      end
      if (pchk)
      begin
         e = q.pop_front();
         `CHK({30'h0, irq_o, pin}, e)
      end
      if (hreadyout_o) rdp = hsel_i && htrans_i[1] && !hwrite_i;
   end
   task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
      hsel_i <= 1'b1;
      haddr_i <= a;
      hwrite_i <= w;
      htrans_i <= 2'h2;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      htrans_i <= 2'h0;
      hwdata_i <= d;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
   endtask : bus
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      q.push_back(x);
      bus(a, 1'b0, 32'h0);
   endtask : rd
   task automatic ms(input logic p, input logic [15:0] v);
      if (p) ps_meas_i <= {1'b1, v};
      else al_meas_i <= {1'b1, v};
      @(posedge clk_i);
      ps_meas_i.valid <= 1'b0;
      al_meas_i.valid <= 1'b0;
      @(posedge clk_i);
   endtask : ms
   task automatic pin_chk(input logic [1:0] x);
      @(posedge clk_i);
      q.push_back({30'h0, x});
      pchk <= 1'b1;
      @(posedge clk_i);
      pchk <= 1'b0;
   endtask : pin_chk
   task automatic end_sim();
      if (mismatches == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   // watchdog
   initial
   begin
      #500000;
      mismatches++;
      end_sim();
   end
   // main sequence
   initial
   begin
      {hsel_i, haddr_i, htrans_i, hwrite_i, hwdata_i, ps_meas_i, al_meas_i} = '0;
      hsize_i = 3'h2;
      resetn_i = 1'b0;
      lc = 8'hFF;
      repeat (5) @(posedge clk_i);
      resetn_i <= 1'b1;
      rd(`LPT_OFF_CTRL, `LPT_RST_CTRL);
      rd(`LPT_OFF_PS_THR, `LPT_RST_THR);
      rd(`LPT_OFF_MASK, 32'h0);
      rd(12'h040, 32'h0);
      bus(`LPT_OFF_MASK, 1'b1, 32'h3);
      bus(`LPT_OFF_PS_THR, 1'b1, 32'h00C8_0064);
      bus(`LPT_OFF_AL_THR, 1'b1, 32'h012C_0064);
      // table of mode, channel, expected activity and count
      for (i = 0; i < 17; i++)
      begin
         if (tbl[i][31:24] !== lc) bus(`LPT_OFF_CTRL, 1'b1, {24'h0, tbl[i][31:24]});
         lc = tbl[i][31:24];
         ms(tbl[i][20], tbl[i][15:0]);
         pin_chk({1'b1, !tbl[i][16]});
      end
      bus(`LPT_OFF_CTRL, 1'b1, 32'h21);
      for (i = 0; i < 20; i++)
      begin
         c = 16'($unsigned($random(seed)) % 301);
         pv = c inside {[100:200]};
         ms(1'b1, c);
         pin_chk({1'b1, pv});
      end
      // sticky status, mask and write-one-to-clear
      rd(`LPT_OFF_STAT, 32'h3);
      bus(`LPT_OFF_MASK, 1'b1, 32'h1);
      bus(`LPT_OFF_STAT, 1'b1, 32'h1);
      rd(`LPT_OFF_STAT, 32'h2);
      pin_chk({1'b0, pv});
      bus(`LPT_OFF_MASK, 1'b1, 32'h0);
      // latched output, clears and power down
      bus(`LPT_OFF_CTRL, 1'b1, 32'h25);
      ms(1'b1, 16'h00C9);
      pin_chk(2'h0);
      ms(1'b1, 16'h0096);
      pin_chk(2'h0);
      bus(`LPT_OFF_CMD, 1'b1, 32'h1);
      pin_chk(2'h1);
      ms(1'b1, 16'h0032);
      rd(`LPT_OFF_INTREG, 32'h5);
      pin_chk(2'h1);
      ms(1'b1, 16'h0032);
      rd(`LPT_OFF_PS_CNT, 32'h0000_0032);
      rd(`LPT_OFF_AL_CNT, 32'h0000_012C);
      bus(`LPT_OFF_CMD, 1'b1, 32'h4);
      bus(`LPT_OFF_CMD, 1'b1, 32'h5);
      pin_chk(2'h0);
      bus(`LPT_OFF_CMD, 1'b1, 32'h2);
      pin_chk(2'h1);
      rd(`LPT_OFF_CTRL, `LPT_RST_CTRL);
      end_sim();
   end
endmodule : lpt_irq_test
